// [rwc_checker.sv]
`timescale 1ns/100ps
module rwc_checker #(
  parameter int unsigned STARTUP_BASE_CYC = 8,
  parameter int unsigned BOD_MIN_CYC      = 4
) (
  input wire logic       ref_clk_in,
  input wire logic       arst_n_in,
  input wire logic       por_low_in,
  input wire logic       reset_pin_n_in,
  input wire logic       brownout_low_in,
  input wire logic [2:0] brownout_level_fuse_in,
  input wire logic       irq_ack_in,
  input wire logic       adc_enable_in,
  input wire logic       dac_enable_in,
  input wire logic       rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       sys_reset_out,
  input wire logic       wdog_irq_out,
  input wire logic       bandgap_en_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_pin_up;
    $rose(reset_pin_n_in) && !por_low_in && !brownout_low_in;
  endsequence
  sequence s_bod_long;
    (brownout_low_in && brownout_level_fuse_in != 3'h7) [*8];
  endsequence
  chk_rd_idle: assert property (!rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data outside read slot");
  chk_por_set: assert property (por_low_in |-> sys_reset_out)
    else $error("power-on low without reset");
  chk_pin_set: assert property (!reset_pin_n_in |-> sys_reset_out)
    else $error("reset pin low without reset");
  chk_bg_on: assert property (adc_enable_in || dac_enable_in |=> bandgap_en_out)
    else $error("bandgap off while needed");
  chk_ack_clears: assert property (irq_ack_in && wdog_irq_out |-> ##[1:2] !wdog_irq_out)
    else $error("interrupt not cleared by ack");
  chk_start_hold: assert property (s_pin_up |-> sys_reset_out [*8])
    else $error("start-up delay too short");
  chk_rst_irq: assert property (sys_reset_out [*3] |-> !wdog_irq_out)
    else $error("interrupt during reset");
  chk_bod_trip: assert property (s_bod_long |-> ##[0:3] sys_reset_out)
    else $error("brown-out without reset");
endmodule

bind rwc_top rwc_checker #(.STARTUP_BASE_CYC(STARTUP_BASE_CYC), .BOD_MIN_CYC(BOD_MIN_CYC)) u_chk (
  .ref_clk_in, .arst_n_in, .por_low_in, .reset_pin_n_in, .brownout_low_in,
  .brownout_level_fuse_in, .irq_ack_in, .adc_enable_in, .dac_enable_in, .rd_en_in,
  .rd_data_out, .sys_reset_out, .wdog_irq_out, .bandgap_en_out
);

// [rwc_core_model.sv]
`timescale 1ns/100ps
module rwc_core_model (
  input  wire logic ref_clk_in,
  input  wire logic irq_in,
  input  wire logic kick_en_in,
  input  wire logic ack_en_in,
  output logic      tick_out,
  output logic      restart_out,
  output logic      ack_out
);
  logic [9:0] cnt_q = 10'h000;
  logic       ack_q = 1'b0;
  assign tick_out    = cnt_q[0];
  assign restart_out = kick_en_in && (cnt_q == 10'h3ff);
  assign ack_out     = ack_q;
  always @(posedge ref_clk_in)
  begin
    cnt_q <= cnt_q + 10'h001;
    ack_q <= ack_en_in && irq_in && !ack_q;
  end
endmodule

// [rwc_pkg.sv]
package rwc_pkg;

  typedef enum logic [1:0] {
    RWC_HOLD,
    RWC_COUNT,
    RWC_RUN
  } rwc_state_t;

endpackage

// [rwc_regs.svh]
`ifndef RWC_REGS_SVH
`define RWC_REGS_SVH

// Register addresses on the plain register port.
`define RWC_ADDR_STATUS     8'h00
`define RWC_ADDR_CTRL       8'h01
`define RWC_ADDR_MISC       8'h02

// Status register fields.
`define RWC_STAT_POWERON    0
`define RWC_STAT_EXTERNAL   1
`define RWC_STAT_BROWNOUT   2
`define RWC_STAT_WDOG       3

// Watchdog control register fields.
`define RWC_CTRL_PERIOD_LO  0
`define RWC_CTRL_RESET_EN   3
`define RWC_CTRL_UNLOCK     4
`define RWC_CTRL_PERIOD_HI  5
`define RWC_CTRL_IRQ_EN     6
`define RWC_CTRL_TIMEOUT    7

// Miscellaneous register fields.
`define RWC_MISC_CMP_BG     0

// Reset values.
`define RWC_STATUS_RST      4'h1
`define RWC_PERIOD_RST      4'h0

// Watchdog timing: base limit in oscillator cycles, top period select, unlock window in clock cycles.
`define RWC_WDOG_MIN_CYC    21'h000800
`define RWC_WDOG_MAX_SEL    4'h9
`define RWC_UNLOCK_CYC      3'h4

// Clock rate and derived times.
`define RWC_CLK_MHZ         125
`define RWC_BOD_MIN_NS      2000
`define RWC_BOD_MIN_CYC     ((`RWC_BOD_MIN_NS * `RWC_CLK_MHZ + 999) / 1000)
`define RWC_STARTUP_US      1000
`define RWC_STARTUP_CYC     (`RWC_STARTUP_US * `RWC_CLK_MHZ)

`endif

// [rwc_top.sv]
// Notes on behaviour
// R1: Any reset returns control registers to initial values; core restarts at reset vector.
// R2: Port reset asserts asynchronously from active sources, needing no clock; here only pin and power-on do, brown-out and watchdog need the clock.
// R3: After all sources drop, a fuse-selected delay holds reset before running.
// R4: Four reset sources merge: power-on, external pin, watchdog, brown-out.
// R5: Power-on indication asserts reset at once; its release starts the delay.
// R6: External pin low resets without clock; delay runs after it rises.
// R7: Enabled brown-out asserts reset at once; delay completes after it clears.
// R8: Brown-out counts only when low supply lasts beyond the minimum duration.
// R9: Watchdog reset is a one-cycle pulse; delay starts on its falling edge.
// R10: Bandgap is on for brown-out, comparator select, ADC or DAC.
// R11: Watchdog counts its own oscillator ticks and acts at the selected limit.
// R12: Restart instruction clears the watchdog counter to zero.
// R13: Modes are interrupt, reset, and interrupt then switch to reset.
// R14: Watchdog keeps running in sleep so its interrupt can wake the core.
// R15: Always-on fuse forces reset mode: reset enable one, interrupt enable zero.
// R16: Firmware opens a change by writing unlock and reset enable together.
// R17: Within four cycles one write with unlock clear may change protected fields; here every such write inside the open window does.
// R18: Period select chooses time-outs from the shortest to the longest setting.
// R19: Shortening the period does not clear the counter and may time out.
// R20: After watchdog reset, reset mode stays until flag then enable are cleared.
// R21: Reset enable reads one while watchdog reset flag is set.
// R22: Hardware clears the unlock bit four clock cycles after it is set.
// R23: Time-out flag sets in interrupt mode; clears on vector or writing one.
// R24: A watchdog-caused reset sets the watchdog reset flag.
// R25: Protected fields ignore changes outside an open unlock window.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "rwc_regs.svh"

module rwc_top #(
  parameter int unsigned STARTUP_BASE_CYC = `RWC_STARTUP_CYC,
  parameter int unsigned BOD_MIN_CYC      = `RWC_BOD_MIN_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       ce_in,
  input  wire logic       por_low_in,
  input  wire logic       reset_pin_n_in,
  input  wire logic       brownout_low_in,
  input  wire logic [2:0] brownout_level_fuse_in,
  input  wire logic [1:0] startup_time_fuse_in,
  input  wire logic       wdog_forced_on_fuse_in,
  input  wire logic       wdog_osc_tick_in,
  input  wire logic       wdog_restart_in,
  input  wire logic       irq_ack_in,
  input  wire logic       adc_enable_in,
  input  wire logic       dac_enable_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  output logic      [7:0] rd_data_out,
  output logic            sys_reset_out,
  output logic            wdog_irq_out,
  output logic            bandgap_en_out
);

  function automatic logic [20:0] wdog_limit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `RWC_WDOG_MAX_SEL) ? `RWC_WDOG_MAX_SEL : sel;
    return `RWC_WDOG_MIN_CYC << s;
  endfunction

  // Reset merge and start-up delay.
  rwc_pkg::rwc_state_t state_q;
  rwc_pkg::rwc_state_t state_d;
  logic [23:0]         delay_q;
  logic [23:0]         delay_d;
  logic                sys_rst_q;
  logic                wdog_pulse_q;
  logic                bod_det_q;
  logic [11:0]         bod_cnt_q;

  // Watchdog and registers.
  logic [20:0]         wdog_cnt_q;
  logic [3:0]          period_q;
  logic                wde_q;
  logic                wdog_irq_enable_q;
  logic                wdog_timeout_flag_q;
  logic [2:0]          unlock_q;
  logic                comparator_bandgap_select_q;
  logic [3:0]          status_q;
  logic                irq_q;
  logic                bandgap_q;
  logic [7:0]          rd_data_q;

  wire logic bod_enable = (brownout_level_fuse_in != 3'h7);
  // The pin and the power-on indication reset the sequencer directly, with no clock needed.
  wire logic rst_src_n  = arst_n_in & reset_pin_n_in & ~por_low_in; // R2 R5 R6
  wire logic src_active = ~reset_pin_n_in | por_low_in | bod_det_q | wdog_pulse_q; // R4 R7 R9
  wire logic [23:0] startup_cyc = 24'(STARTUP_BASE_CYC) << startup_time_fuse_in; // R3

  always_comb
  begin
    state_d = state_q;
    delay_d = delay_q;
    if (src_active)
    begin
      state_d = rwc_pkg::RWC_HOLD;
      delay_d = startup_cyc;
    end
    else
    begin
      unique case (state_q)
        rwc_pkg::RWC_HOLD:
        begin
          state_d = rwc_pkg::RWC_COUNT; // R3
          delay_d = startup_cyc;
        end
        rwc_pkg::RWC_COUNT:
        begin
          if (delay_q <= 24'h000001)
          begin
            state_d = rwc_pkg::RWC_RUN;
          end
          delay_d = delay_q - 24'h000001;
        end
        rwc_pkg::RWC_RUN:
        begin
          state_d = rwc_pkg::RWC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_src_n)
  begin
    if (!rst_src_n)
    begin
      state_q   <= rwc_pkg::RWC_HOLD; // R2
      delay_q   <= 24'h000000;
      sys_rst_q <= 1'b1; // R2
    end
    else if (ce_in)
    begin
      state_q   <= state_d;
      delay_q   <= delay_d;
      sys_rst_q <= (state_d != rwc_pkg::RWC_RUN); // R3
    end
  end

  // Brown-out filter.
  wire logic bod_low = brownout_low_in & bod_enable;

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bod_cnt_q <= 12'h000;
      bod_det_q <= 1'b0;
    end
    else if (ce_in)
    begin
      bod_cnt_q <= (bod_low && !bod_det_q) ? bod_cnt_q + 12'h001 : 12'h000; // R8
      bod_det_q <= bod_low && (bod_det_q || bod_cnt_q >= 12'(BOD_MIN_CYC)); // R8 R7
    end
  end

  // Effective watchdog mode.
  wire logic eff_wde  = wde_q | status_q[`RWC_STAT_WDOG] | wdog_forced_on_fuse_in; // R15 R20 R21
  wire logic eff_wdog_irq_enable = wdog_irq_enable_q & ~wdog_forced_on_fuse_in; // R15
  wire logic wdog_on  = eff_wde | eff_wdog_irq_enable;
  wire logic expire   = wdog_on & wdog_osc_tick_in
                        & (wdog_cnt_q >= wdog_limit(period_q) - 21'h000001); // R11 R18 R19
  wire logic irq_fire = expire & eff_wdog_irq_enable & ~(eff_wde & wdog_timeout_flag_q); // R13 R23
  wire logic rst_fire = expire & eff_wde & (~eff_wdog_irq_enable | wdog_timeout_flag_q); // R13
  // A period change leaves the count alone, so a shorter period may expire at once.
  wire logic wdog_clr = ~wdog_on | wdog_restart_in | expire | sys_rst_q; // R12 R19

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wdog_cnt_q   <= 21'h000000;
      wdog_pulse_q <= 1'b0;
    end
    else if (ce_in)
    begin
      wdog_pulse_q <= rst_fire; // R9
      if (wdog_clr)
      begin
        wdog_cnt_q <= 21'h000000; // R12
      end
      else if (wdog_osc_tick_in)
      begin
        wdog_cnt_q <= wdog_cnt_q + 21'h000001; // R11 R14
      end
    end
  end

  // Register port decode; one select word serves both the write and the read path.
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    return {addr == `RWC_ADDR_MISC, addr == `RWC_ADDR_CTRL, addr == `RWC_ADDR_STATUS};
  endfunction

  wire logic [2:0] sel_hit = reg_sel(addr_in);
  wire logic wr_stat = wr_en_in & sel_hit[0];
  wire logic wr_ctrl = wr_en_in & sel_hit[1];
  wire logic wr_misc = wr_en_in & sel_hit[2];

  wire logic win_open   = (unlock_q != 3'h0);
  wire logic unlock_req = wr_ctrl & wr_data_in[`RWC_CTRL_UNLOCK]
                          & wr_data_in[`RWC_CTRL_RESET_EN]; // R16
  wire logic prot_write = wr_ctrl & win_open & ~wr_data_in[`RWC_CTRL_UNLOCK]; // R17 R25

  wire logic [3:0] period_d = prot_write ? {wr_data_in[`RWC_CTRL_PERIOD_HI],
                                            wr_data_in[2:0]} : period_q; // R17 R25
  wire logic wde_clear = prot_write & ~wr_data_in[`RWC_CTRL_RESET_EN]
                         & ~status_q[`RWC_STAT_WDOG]; // R21 R25
  wire logic wde_set   = wr_ctrl & wr_data_in[`RWC_CTRL_RESET_EN];
  wire logic wde_d     = wde_set | (wde_q & ~wde_clear);
  wire logic wdog_irq_enable_d    = wr_ctrl ? wr_data_in[`RWC_CTRL_IRQ_EN]
                                 : (wdog_irq_enable_q & ~(irq_ack_in & eff_wde)); // R13
  wire logic wdog_timeout_flag_clr  = (wr_ctrl & wr_data_in[`RWC_CTRL_TIMEOUT]) | irq_ack_in; // R23
  wire logic wdog_timeout_flag_d    = irq_fire | (wdog_timeout_flag_q & ~wdog_timeout_flag_clr); // R23
  wire logic [2:0] unlock_d = unlock_req ? `RWC_UNLOCK_CYC
                              : (win_open ? unlock_q - 3'h1 : 3'h0); // R22
  wire logic comparator_bandgap_select_d    = wr_misc ? wr_data_in[`RWC_MISC_CMP_BG] : comparator_bandgap_select_q;

  // Control fields; a running reset sequence holds them at their initial values.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      period_q <= `RWC_PERIOD_RST;
      wde_q    <= 1'b0;
      wdog_irq_enable_q   <= 1'b0;
      wdog_timeout_flag_q   <= 1'b0;
    end
    else if (ce_in && sys_rst_q)
    begin
      period_q <= `RWC_PERIOD_RST; // R1
      wde_q    <= 1'b0;
      wdog_irq_enable_q   <= 1'b0;
      wdog_timeout_flag_q   <= 1'b0;
    end
    else if (ce_in)
    begin
      period_q <= period_d;
      wde_q    <= wde_d;
      wdog_irq_enable_q   <= wdog_irq_enable_d;
      wdog_timeout_flag_q   <= wdog_timeout_flag_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      unlock_q <= 3'h0;
    end
    else if (ce_in)
    begin
      unlock_q <= sys_rst_q ? 3'h0 : unlock_d; // R22
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      comparator_bandgap_select_q <= 1'b0;
    end
    else if (ce_in)
    begin
      comparator_bandgap_select_q <= sys_rst_q ? 1'b0 : comparator_bandgap_select_d; // R1
    end
  end

  // Reset cause flags; write zero clears, a new cause wins over the clear.
  wire logic [3:0] stat_keep = wr_stat ? (status_q & wr_data_in[3:0]) : status_q;
  wire logic [3:0] stat_set  = {wdog_pulse_q, bod_det_q, ~reset_pin_n_in, 1'b0};
  localparam logic [3:0] STAT_RST = `RWC_STATUS_RST;
  wire logic [3:0] status_d;

  // Power-on presets the whole word, so it overrides every per-bit merge.
  for (genvar i = 0; i < 4; i++)
  begin : g_stat
    assign status_d[i] = por_low_in ? STAT_RST[i] : (stat_keep[i] | stat_set[i]); // R24
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      status_q <= `RWC_STATUS_RST;
    end
    else if (ce_in)
    begin
      status_q <= status_d;
    end
  end

  // Read data and registered outputs.
  wire logic [7:0] ctrl_rd = {wdog_timeout_flag_q, eff_wdog_irq_enable, period_q[3], win_open, eff_wde,
                              period_q[2:0]}; // R21 R15
  wire logic [7:0] rd_mux  = sel_hit[0] ? {4'h0, status_q} :
                             sel_hit[1] ? ctrl_rd :
                             sel_hit[2] ? {7'h00, comparator_bandgap_select_q} : 8'h00;
  wire logic bandgap_d = bod_enable | comparator_bandgap_select_q | adc_enable_in | dac_enable_in; // R10
  wire logic [7:0] rd_data_d = rd_en_in ? rd_mux : 8'h00;
  wire logic irq_d     = wdog_timeout_flag_d & eff_wdog_irq_enable; // R14 R23

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_data_q <= 8'h00;
    end
    else if (ce_in)
    begin
      rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_q <= 1'b0;
    end
    else if (ce_in)
    begin
      irq_q <= irq_d; // R14 R23
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bandgap_q <= 1'b0;
    end
    else if (ce_in)
    begin
      bandgap_q <= bandgap_d; // R10
    end
  end

  assign rd_data_out    = rd_data_q;
  assign sys_reset_out  = sys_rst_q;
  assign wdog_irq_out   = irq_q;
  assign bandgap_en_out = bandgap_q;

endmodule

// [test_rwc_top.sv]
`timescale 1ns/100ps
module test_rwc_top;
  logic       ref_clk_in = 1'b0, arst_n_in = 1'b0, por_low_in = 1'b0, reset_pin_n_in = 1'b1;
  logic       brownout_low_in = 1'b0, wdog_forced_on_fuse_in = 1'b0, kick_en = 1'b0;
  logic       adc_enable_in = 1'b0, dac_enable_in = 1'b0, ack_en = 1'b0;
  logic       wr_en_in = 1'b0, rd_en_in = 1'b0, sys_reset_out, wdog_irq_out, bandgap_en_out;
  logic       wdog_osc_tick_in, wdog_restart_in, irq_ack_in;
  logic [2:0] brownout_level_fuse_in = 3'h7;
  logic [1:0] startup_fuse = 2'h0;
  logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00, rd_data_out;
  logic [31:0] r;
  int         err_total = 0, tests_run = 0, n;
  always #4 ref_clk_in = ~ref_clk_in;
  rwc_top #(.STARTUP_BASE_CYC(8), .BOD_MIN_CYC(4)) u_rwc_top (
    .ref_clk_in, .arst_n_in, .ce_in(1'b1), .por_low_in, .reset_pin_n_in, .brownout_low_in,
    .brownout_level_fuse_in, .startup_time_fuse_in(startup_fuse), .wdog_forced_on_fuse_in,
    .wdog_osc_tick_in, .wdog_restart_in, .irq_ack_in, .adc_enable_in, .dac_enable_in,
    .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .sys_reset_out,
    .wdog_irq_out, .bandgap_en_out);
  rwc_core_model u_rwc_core_model (.ref_clk_in, .irq_in(wdog_irq_out), .kick_en_in(kick_en),
    .ack_en_in(ack_en), .tick_out(wdog_osc_tick_in), .restart_out(wdog_restart_in),
    .ack_out(irq_ack_in));
  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction
  task automatic complete_run();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
    #1;
    cmp(rd_data_out, exp);
    @(posedge ref_clk_in);
  endtask
  task automatic wait_for(input logic s, input logic v, input int lim);
    for (n = 0; n < lim; n++)
    begin
      @(posedge ref_clk_in);
      #1;
      if ((s ? wdog_irq_out : sys_reset_out) === v)
        return;
    end
    err_total++;
    complete_run();
  endtask
  initial
  begin
    r = $urandom(32'h763f);
    repeat (10) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    wait_for(1'b0, 1'b0, 100);
    cmp(b(n >= 8), 8'h01);
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      adc_enable_in <= r[0];
      dac_enable_in <= r[1];
      wr(8'h02, b(r[2]));
      rd({1'b1, r[9:3]}, 8'h00);
      cmp(b(bandgap_en_out), b(|r[2:0]));
    end
    wr(8'h01, 8'h40);
    wait_for(1'b1, 1'b1, 5000);
    cmp(b(n >= 4000), 8'h01);
    rd(8'h01, 8'hc0);
    wr(8'h01, 8'hc0);
    rd(8'h01, 8'h40);
    kick_en <= 1'b1;
    repeat (6000) @(posedge ref_clk_in);
    cmp(b(wdog_irq_out), 8'h00);
    kick_en <= 1'b0;
    wr(8'h01, 8'h08);
    wr(8'h01, 8'h01);
    rd(8'h01, 8'h08);
    wr(8'h01, 8'h18);
    wr(8'h01, 8'h01);
    rd(8'h01, 8'h11);
    wr(8'h01, 8'h18);
    repeat (4) @(posedge ref_clk_in);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h09);
    wait_for(1'b0, 1'b1, 9000);
    wait_for(1'b0, 1'b0, 100);
    rd(8'h00, 8'h08);
    wr(8'h01, 8'h18);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h18);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h18);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h10);
    ack_en <= 1'b1;
    wr(8'h01, 8'h48);
    wait_for(1'b0, 1'b1, 9000);
    cmp(b(n >= 6000), 8'h01);
    wait_for(1'b0, 1'b0, 100);
    wr(8'h00, 8'h00);
    wdog_forced_on_fuse_in <= 1'b1;
    wr(8'h01, 8'h40);
    rd(8'h01, 8'h08);
    wdog_forced_on_fuse_in <= 1'b0;
    reset_pin_n_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    cmp(b(sys_reset_out), 8'h01);
    reset_pin_n_in <= 1'b1;
    wait_for(1'b0, 1'b0, 100);
    rd(8'h00, 8'h02);
    wr(8'h00, 8'h00);
    brownout_level_fuse_in <= 3'h0;
    brownout_low_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    brownout_low_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    cmp(b(sys_reset_out), 8'h00);
    brownout_low_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    brownout_low_in <= 1'b0;
    cmp(b(sys_reset_out), 8'h01);
    wait_for(1'b0, 1'b0, 100);
    rd(8'h00, 8'h04);
    startup_fuse <= 2'h1;
    por_low_in <= 1'b1;
    #1;
    cmp(b(sys_reset_out), 8'h01);
    @(posedge ref_clk_in);
    por_low_in <= 1'b0;
    wait_for(1'b0, 1'b0, 100);
    cmp(b(n >= 16 && n < 20), 8'h01);
    rd(8'h00, 8'h01);
    complete_run();
  end
endmodule
